/* shared/ddrcmd_pkg.sv */
// Package for the DDR SDRAM command decoder and init tracker.
// Assumes one 20 MHz system clock; the memory clock is sampled as a pin.
package ddrcmd_pkg;

  // ----------------------------------------------------------------
  // Widths and configurations
  // ----------------------------------------------------------------
  localparam int ADDR_W = 13;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int DATA_N = 8;
  localparam int AUTO_CLOSE_BIT_X32 = 8;
  localparam int AUTO_CLOSE_BIT_NARROW = 10;
  localparam int DLL_RESET_BIT = 8;
  localparam int MODE_OP_LO = 7;
  localparam int CFG_W = 2;
  localparam logic [1:0] CFG_X8 = 2'h0;
  localparam logic [1:0] CFG_X16 = 2'h1;
  localparam logic [1:0] CFG_X32 = 2'h2;
  localparam logic [1:0] SEL_BASE = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h1;
  localparam logic [3:0] ALL_IDLE = 4'h0;
  localparam logic [3:0] ONE_BANK = 4'h1;
  localparam logic [12:0] ADDR_ZERO = 13'h0000;
  localparam logic [12:0] MODE_ZERO = 13'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Command pins (cs_n, ras_n, cas_n, we_n)
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic [1:0] bank;
    logic [12:0] addr;
  } ddrcmd_bus_t;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_ROW_OPEN = 4'h1,
    CMD_READ = 4'h2,
    CMD_WRITE = 4'h3,
    CMD_BURST_STOP = 4'h4,
    CMD_PRECHARGE = 4'h5,
    CMD_REFRESH = 4'h6,
    CMD_MODE_LOAD = 4'h7
  } ddrcmd_cmd_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_PD_PRE = 6'h02,
    ST_PD_ACT = 6'h04,
    ST_SELF_REF = 6'h08,
    ST_NORMAL = 6'h10
  } ddrcmd_state_t;

  // Init progress counters.
  localparam logic [1:0] MIN_REFRESHES = 2'h2;

  // Decodes the four command pins into a command.
  function automatic ddrcmd_cmd_t ddrcmd_decode(input ddrcmd_bus_t b);
    ddrcmd_cmd_t c;
    c = CMD_NOP;
    if (!b.cs_n) begin
      unique case ({b.ras_n, b.cas_n, b.we_n})
        3'h3: c = CMD_ROW_OPEN;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h6: c = CMD_BURST_STOP;
        3'h2: c = CMD_PRECHARGE;
        3'h1: c = CMD_REFRESH;
        3'h0: c = CMD_MODE_LOAD;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

endpackage

/* hw/ddrcmd_core.sv */
// Command decode, power state and init tracking of a four-bank DDR SDRAM.
// Assumes the memory clock and command pins arrive asynchronously.
`timescale 1ns/1ps

// What this block does
// - Auto-close flag acts only on its own access; deselect equals no-op.
// - Auto-close flag sits on A8 for 32-bit, A10 for 8/16-bit.
// - Precharge closes named bank, or every bank when flag is high.
// - Refresh with gate high refreshes once; gate drop enters self refresh.
// - Refresh ignores address and data; internal counter picks the row.
// - Bank-select bits choose which mode register a mode load writes.
// - Write mask low stores data, high blocks it, per data element.
// - Row address uses A0 to A12; auto-close bit excluded from column.
// - Clock-gate drop with no-op and all idle enters precharge power-down.
// - Clock-gate drop with bank open enters active power-down; rise exits.
// - Each access moves one 2n word at core, two n halves at pins.
// - Row open selects bank and row; read or write selects column.
// - Mode registers have no default; clock stop unusable until both mode loads and two refreshes are done.
// - Mode load with banks 00 writes base, 01 writes extended.
// - Base load with A8 set resets the loop; later load clears it.
module ddrcmd_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] width_cfg,
  input wire logic mem_clk,
  input wire ddrcmd_pkg::ddrcmd_bus_t cmd_pins,
  input wire logic write_mask_pin,
  input wire logic [15:0] dq_in,
  output logic [3:0] bank_open,
  output logic [12:0] open_row [4],
  output logic [12:0] col_addr,
  output logic [1:0] col_bank,
  output logic rd_start,
  output logic wr_start,
  output logic auto_close_flag,
  output logic [12:0] base_mode,
  output logic [12:0] ext_mode,
  output logic base_loaded,
  output logic ext_loaded,
  output logic dll_reset_pulse,
  output logic init_done,
  output logic refresh_pulse,
  output logic [12:0] refresh_row,
  output logic [1:0] refresh_bank,
  output logic self_refresh,
  output logic power_down,
  output logic active_power_down,
  output logic [15:0] core_word,
  output logic core_word_valid,
  output logic [1:0] core_mask,
  output logic reserved_seen
);
  import ddrcmd_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers and memory clock edge detect
  // ----------------------------------------------------------------
  localparam int SYNC_W = 1 + $bits(ddrcmd_bus_t) + 1 + 16;
  logic [SYNC_W-1:0] s1_q, s2_q;
  logic ck_prev_q, ck_prev_d;
  logic ck_s, ck_rise, ck_fall, mask_s;
  ddrcmd_bus_t bus_s;
  logic [15:0] dq_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      ck_prev_q <= 1'b0;
    end else begin
      s1_q <= {mem_clk, cmd_pins, write_mask_pin, dq_in};
      s2_q <= s1_q;
      ck_prev_q <= ck_prev_d;
    end
  end

  always_comb begin
    {ck_s, bus_s, mask_s, dq_s} = s2_q;
    ck_prev_d = ck_s;
    ck_rise = ck_s & ~ck_prev_q;
    ck_fall = ~ck_s & ck_prev_q;
  end

  // ----------------------------------------------------------------
  // Command state
  // ----------------------------------------------------------------
  ddrcmd_cmd_t cmd;
  ddrcmd_state_t st_q, st_d;
  logic cke_prev_q, cke_prev_d;
  logic [3:0] open_q, open_d;
  logic [12:0] row_q [4];
  logic [12:0] row_d [4];
  logic [12:0] col_q, col_d, bmode_q, bmode_d, emode_q, emode_d;
  logic [1:0] cbank_q, cbank_d;
  logic rd_q, rd_d, wr_q, wr_d, ac_q, ac_d;
  logic bl_q, bl_d, el_q, el_d, dll_q, dll_d;
  logic [1:0] refcnt_q, refcnt_d;
  logic ref_q, ref_d, resv_q, resv_d;
  logic [14:0] rctr_q, rctr_d;
  logic ap;
  logic [12:0] col_raw;

  always_comb begin
    cmd = ddrcmd_decode(bus_s);
    // Auto-close bit position depends on the width option.
    ap = (width_cfg == CFG_X32) ? bus_s.addr[AUTO_CLOSE_BIT_X32]
                                : bus_s.addr[AUTO_CLOSE_BIT_NARROW];
    col_raw = bus_s.addr;
    if (width_cfg == CFG_X32) col_raw[AUTO_CLOSE_BIT_X32] = 1'b0;
    else col_raw[AUTO_CLOSE_BIT_NARROW] = 1'b0;
    st_d = st_q;
    cke_prev_d = cke_prev_q;
    open_d = open_q;
    row_d = row_q;
    col_d = col_q;
    cbank_d = cbank_q;
    rd_d = 1'b0;
    wr_d = 1'b0;
    ac_d = ac_q;
    bmode_d = bmode_q;
    emode_d = emode_q;
    bl_d = bl_q;
    el_d = el_q;
    dll_d = 1'b0;
    refcnt_d = refcnt_q;
    ref_d = 1'b0;
    resv_d = resv_q;
    rctr_d = rctr_q;
    if (ck_rise) begin
      cke_prev_d = bus_s.cke;
      unique case (st_q)
        ST_PD_PRE, ST_PD_ACT, ST_SELF_REF: begin
          // Stay while clock-gate low; leave on rise with a no-op.
          if (bus_s.cke) begin
            if (cmd == CMD_NOP) st_d = ST_NORMAL;
            else resv_d = 1'b1;
          end
        end
        ST_IDLE, ST_NORMAL: begin
          if (cke_prev_q && !bus_s.cke) begin
            if (cmd == CMD_NOP && open_q == ALL_IDLE) begin
              st_d = ST_PD_PRE;
            end else if (cmd == CMD_NOP) begin
              st_d = ST_PD_ACT;
            end else if (cmd == CMD_REFRESH && open_q == ALL_IDLE) begin
              st_d = ST_SELF_REF;
            end else begin
              resv_d = 1'b1;
            end
            // Clock stop is not offered before both mode loads and two refreshes are done.
            if (!(bl_q && el_q && refcnt_q == MIN_REFRESHES))
              resv_d = 1'b1;
          end else if (bus_s.cke) begin
            unique case (cmd)
              CMD_ROW_OPEN: begin
                open_d[bus_s.bank] = 1'b1;
                row_d[bus_s.bank] = bus_s.addr;
              end
              CMD_READ, CMD_WRITE: begin
                cbank_d = bus_s.bank;
                col_d = col_raw;
                ac_d = ap;
                rd_d = (cmd == CMD_READ);
                wr_d = (cmd == CMD_WRITE);
                if (!open_q[bus_s.bank]) resv_d = 1'b1;
                if (ap) open_d[bus_s.bank] = 1'b0;
              end
              CMD_PRECHARGE: begin
                if (ap) open_d = ALL_IDLE;
                else open_d[bus_s.bank] = 1'b0;
              end
              CMD_REFRESH: begin
                // Address pins are ignored; the counter picks the row.
                ref_d = 1'b1;
                rctr_d = rctr_q + 15'h0001;
                if (refcnt_q != MIN_REFRESHES)
                  refcnt_d = refcnt_q + 2'h1;
                if (open_q != ALL_IDLE) resv_d = 1'b1;
              end
              CMD_MODE_LOAD: begin
                if (bus_s.bank == SEL_BASE) begin
                  bmode_d = bus_s.addr;
                  bl_d = 1'b1;
                  dll_d = bus_s.addr[DLL_RESET_BIT];
                end else if (bus_s.bank == SEL_EXT) begin
                  emode_d = bus_s.addr;
                  el_d = 1'b1;
                end else begin
                  resv_d = 1'b1;
                end
              end
              default: ;
            endcase
            if (st_q == ST_IDLE) st_d = ST_NORMAL;
          end
        end
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cke_prev_q <= 1'b0;
      open_q <= ALL_IDLE;
      for (int i = 0; i < BANKS; i++) row_q[i] <= ADDR_ZERO;
      col_q <= ADDR_ZERO;
      cbank_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      ac_q <= 1'b0;
      bmode_q <= MODE_ZERO;
      emode_q <= MODE_ZERO;
      bl_q <= 1'b0;
      el_q <= 1'b0;
      dll_q <= 1'b0;
      refcnt_q <= 2'h0;
      ref_q <= 1'b0;
      resv_q <= 1'b0;
      rctr_q <= 15'h0000;
    end else begin
      st_q <= st_d;
      cke_prev_q <= cke_prev_d;
      open_q <= open_d;
      row_q <= row_d;
      col_q <= col_d;
      cbank_q <= cbank_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      ac_q <= ac_d;
      bmode_q <= bmode_d;
      emode_q <= emode_d;
      bl_q <= bl_d;
      el_q <= el_d;
      dll_q <= dll_d;
      refcnt_q <= refcnt_d;
      ref_q <= ref_d;
      resv_q <= resv_d;
      rctr_q <= rctr_d;
    end
  end

  // ----------------------------------------------------------------
  // Write data pairing: two half-cycle beats form one core word
  // ----------------------------------------------------------------
  logic [7:0] lo_q, lo_d;
  logic mlo_q, mlo_d;
  logic [15:0] word_q, word_d;
  logic [1:0] wmask_q, wmask_d;
  logic wv_q, wv_d;

  always_comb begin
    lo_d = lo_q;
    mlo_d = mlo_q;
    word_d = word_q;
    wmask_d = wmask_q;
    wv_d = 1'b0;
    if (ck_rise) begin
      lo_d = dq_s[DATA_N-1:0];
      mlo_d = mask_s;
    end
    if (ck_fall) begin
      // A high mask bit blocks its beat from being stored.
      word_d = {mask_s ? BYTE_ZERO : dq_s[DATA_N-1:0],
                mlo_q ? BYTE_ZERO : lo_q};
      wmask_d = {mask_s, mlo_q};
      wv_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_q <= BYTE_ZERO;
      mlo_q <= 1'b0;
      word_q <= WORD_ZERO;
      wmask_q <= 2'h0;
      wv_q <= 1'b0;
    end else begin
      lo_q <= lo_d;
      mlo_q <= mlo_d;
      word_q <= word_d;
      wmask_q <= wmask_d;
      wv_q <= wv_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    bank_open = open_q;
    open_row = row_q;
    col_addr = col_q;
    col_bank = cbank_q;
    rd_start = rd_q;
    wr_start = wr_q;
    auto_close_flag = ac_q;
    base_mode = bmode_q;
    ext_mode = emode_q;
    base_loaded = bl_q;
    ext_loaded = el_q;
    dll_reset_pulse = dll_q;
    init_done = bl_q & el_q & (refcnt_q == MIN_REFRESHES)
                & ~bmode_q[DLL_RESET_BIT];
    refresh_pulse = ref_q;
    refresh_row = rctr_q[14:2];
    refresh_bank = rctr_q[1:0];
    self_refresh = (st_q == ST_SELF_REF);
    power_down = (st_q == ST_PD_PRE) | (st_q == ST_PD_ACT);
    active_power_down = (st_q == ST_PD_ACT);
    core_word = word_q;
    core_word_valid = wv_q;
    core_mask = wmask_q;
    reserved_seen = resv_q;
  end

endmodule // ddrcmd_core

/* verification/ddrcmd_ctrl_model.sv */
// Behavioural memory controller driving the core's command and data pins.
// Assumes send is called from the falling edge of clk.
`timescale 1ns/1ps
module ddrcmd_ctrl_model (
  input wire logic clk,
  output logic mem_clk,
  output ddrcmd_pkg::ddrcmd_bus_t cmd_pins,
  output logic write_mask_pin,
  output logic [15:0] dq_in
);
  import ddrcmd_pkg::*;
  // ------------------------------------------------------------
  // One command frame of the memory clock
  // ------------------------------------------------------------
  initial begin
    mem_clk = 1'b0;
    cmd_pins = '0;
    cmd_pins.cs_n = 1'b1;
    cmd_pins.cke = 1'b1;
    write_mask_pin = 1'b0;
    dq_in = WORD_ZERO;
  end
  task automatic send(input logic cs_n, input logic [2:0] op,
      input logic cke, input logic [1:0] ba, input logic [12:0] a,
      input logic [15:0] d, input logic [1:0] m);
    cmd_pins = {cs_n, op, cke, ba, a};
    dq_in = d;
    write_mask_pin = m[0];
    repeat (2) @(negedge clk);
    mem_clk = 1'b1;
    @(negedge clk);
    dq_in = {d[7:0], d[15:8]};
    write_mask_pin = m[1];
    @(negedge clk);
    mem_clk = 1'b0;
    repeat (2) @(negedge clk);
    cmd_pins = {1'b1, ~op, cke, ~ba, ~a};
    dq_in = ~d;
    write_mask_pin = ~m[1];
    repeat (2) @(negedge clk);
  endtask
endmodule // ddrcmd_ctrl_model

/* verification/ddrcmd_asserts.sv */
// Concurrent checks on the ports of the command core.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module ddrcmd_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] width_cfg,
  input wire logic [3:0] bank_open,
  input wire logic [12:0] col_addr,
  input wire logic [1:0] col_bank,
  input wire logic rd_start,
  input wire logic wr_start,
  input wire logic auto_close_flag,
  input wire logic [12:0] base_mode,
  input wire logic base_loaded,
  input wire logic ext_loaded,
  input wire logic dll_reset_pulse,
  input wire logic init_done,
  input wire logic refresh_pulse,
  input wire logic self_refresh,
  input wire logic power_down,
  input wire logic active_power_down,
  input wire logic [15:0] core_word,
  input wire logic core_word_valid,
  input wire logic [1:0] core_mask,
  input wire logic reserved_seen
);
  import ddrcmd_pkg::*;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_access;
    rd_start || wr_start;
  endsequence
  sequence s_close_access;
    s_access ##0 auto_close_flag;
  endsequence
  a_col_flag_clear: assert property (s_access |-> ((width_cfg == CFG_X32) ?
    !col_addr[AUTO_CLOSE_BIT_X32] : !col_addr[AUTO_CLOSE_BIT_NARROW]))
    else $error("auto-close bit left in column");
  a_auto_close_bank: assert property (s_close_access |->
    ##[0:1] !bank_open[col_bank])
    else $error("auto-close access left bank open");
  a_flag_per_cmd: assert property ($changed(auto_close_flag) |->
    s_access)
    else $error("auto-close flag moved without access");
  a_pre_pd_idle: assert property ($rose(power_down) && !active_power_down |->
    bank_open == ALL_IDLE)
    else $error("precharge power-down with open bank");
  a_act_pd_open: assert property ($rose(active_power_down) |->
    bank_open != ALL_IDLE)
    else $error("active power-down with all banks idle");
  a_one_power_state: assert property ($onehot0({self_refresh,
    power_down}))
    else $error("two power states at once");
  a_act_pd_within: assert property (active_power_down |->
    power_down)
    else $error("active power-down outside power-down");
  a_self_ref_idle: assert property ($rose(self_refresh) |->
    bank_open == ALL_IDLE)
    else $error("self refresh with open bank");
  a_refresh_idle: assert property (refresh_pulse |->
    bank_open == ALL_IDLE || reserved_seen)
    else $error("refresh with open bank");
  a_mask_low_beat: assert property (core_word_valid && core_mask[0] |->
    core_word[7:0] == BYTE_ZERO)
    else $error("masked rising beat stored");
  a_mask_high_beat: assert property (core_word_valid && core_mask[1] |->
    core_word[15:8] == BYTE_ZERO)
    else $error("masked falling beat stored");
  a_dll_base_load: assert property (dll_reset_pulse |->
    ##[0:1] base_loaded && base_mode[DLL_RESET_BIT])
    else $error("loop reset without base load");
  a_init_full: assert property (init_done |-> base_loaded && ext_loaded
    && !base_mode[DLL_RESET_BIT])
    else $error("init done too early");
  a_reserved_sticky: assert property (reserved_seen |=> reserved_seen)
    else $error("reserved flag cleared");
endmodule // ddrcmd_asserts
bind ddrcmd_core ddrcmd_asserts ddrcmd_asserts_i (.clk, .rst_n, .width_cfg,
  .bank_open, .col_addr, .col_bank, .rd_start, .wr_start, .auto_close_flag,
  .base_mode, .base_loaded, .ext_loaded, .dll_reset_pulse, .init_done,
  .refresh_pulse, .self_refresh, .power_down, .active_power_down,
  .core_word, .core_word_valid, .core_mask, .reserved_seen);

/* verification/tb_top.sv */
// Self-checking bench of the command core with a controller model.
// Assumes the checker is bound to the core by its own file.
`timescale 1ns/1ps
module tb_top;
  import ddrcmd_pkg::*;
  localparam logic [2:0] OP_ACT = 3'h3;
  localparam logic [2:0] OP_RD = 3'h5;
  localparam logic [2:0] OP_WR = 3'h4;
  localparam logic [2:0] OP_PRE = 3'h2;
  localparam logic [2:0] OP_REF = 3'h1;
  localparam logic [2:0] OP_MODE = 3'h0;
  localparam logic [2:0] OP_NOP = 3'h7;
  logic clk, rst_n, mem_clk, write_mask_pin, rd_start, wr_start;
  logic auto_close_flag, base_loaded, ext_loaded, dll_reset_pulse, init_done;
  logic refresh_pulse, self_refresh, power_down, active_power_down;
  logic core_word_valid, reserved_seen;
  logic [1:0] width_cfg, core_mask, last_mask, col_bank, refresh_bank;
  logic [3:0] bank_open;
  logic [12:0] open_row [4];
  logic [12:0] col_addr, base_mode, ext_mode;
  logic [15:0] dq_in, core_word, last_word;
  ddrcmd_bus_t cmd_pins;
  int error_cnt, cmp_count, n_rd, n_wr, n_ref, n_dll;
  ddrcmd_core ddrcmd_core_i (.clk, .rst_n, .width_cfg, .mem_clk, .cmd_pins,
    .write_mask_pin, .dq_in, .bank_open, .open_row, .col_addr, .col_bank,
    .rd_start, .wr_start, .auto_close_flag, .base_mode, .ext_mode,
    .base_loaded, .ext_loaded, .dll_reset_pulse, .init_done, .refresh_pulse,
    .refresh_row(), .refresh_bank, .self_refresh, .power_down,
    .active_power_down, .core_word, .core_word_valid, .core_mask,
    .reserved_seen);
  ddrcmd_ctrl_model ddrcmd_ctrl_model_i (.clk, .mem_clk, .cmd_pins,
    .write_mask_pin, .dq_in);
  // ------------------------------------------------------------
  // Clock, monitor and helpers
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rd_start === 1'b1) n_rd++;
    if (wr_start === 1'b1) n_wr++;
    if (refresh_pulse === 1'b1) n_ref++;
    if (dll_reset_pulse === 1'b1) n_dll++;
    if (core_word_valid === 1'b1) begin
      last_word = core_word;
      last_mask = core_mask;
    end
  end
  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic s(input logic cs_n, input logic [2:0] op, input logic cke,
      input logic [1:0] ba, input logic [12:0] a);
    ddrcmd_ctrl_model_i.send(cs_n, op, cke, ba, a, WORD_ZERO, 2'h0);
  endtask
  task automatic do_reset(input logic [1:0] cfg);
    @(negedge clk);
    rst_n = 1'b0;
    width_cfg = cfg;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic sc_init();
    int d0, r0;
    d0 = n_dll;
    r0 = n_ref;
    s(1'b0, OP_PRE, 1'b1, 2'h0, 13'h0400);
    s(1'b0, OP_MODE, 1'b1, SEL_EXT, 13'h0002);
    chk("ext_mode", 16'h0002, ext_mode);
    s(1'b0, OP_MODE, 1'b1, SEL_BASE, 13'h0132);
    chk("dll_pulses", 16'h0001, 16'(n_dll - d0));
    repeat (200) s(1'b1, OP_NOP, 1'b1, 2'h0, 13'h0000);
    s(1'b0, OP_PRE, 1'b1, 2'h0, 13'h0400);
    s(1'b0, OP_REF, 1'b1, 2'h3, 13'h1FFF);
    s(1'b0, OP_REF, 1'b1, 2'h0, 13'h0000);
    chk("refreshes", 16'h0002, 16'(n_ref - r0));
    chk("refresh_bank", 16'h0002, 16'(refresh_bank));
    chk("init_early", 16'h0000, init_done);
    s(1'b0, OP_MODE, 1'b1, SEL_BASE, 13'h0032);
    chk("base_mode", 16'h0032, base_mode);
    chk("init_done", 16'h0001, init_done);
  endtask
  task automatic sc_access(input int acb);
    logic [12:0] ac;
    int r0, w0;
    ac = 13'h0001 << acb;
    r0 = n_rd;
    w0 = n_wr;
    s(1'b0, OP_ACT, 1'b1, 2'h1, 13'h1ABC);
    chk("open_row", 16'h1ABC, open_row[1]);
    s(1'b0, OP_RD, 1'b1, 2'h1, 13'h00A5 | ac);
    chk("rd_start", 16'h0001, 16'(n_rd - r0));
    chk("col_addr", 16'h00A5, col_addr);
    chk("flag_high", 16'h0001, auto_close_flag);
    chk("auto_closed", 16'h0000, bank_open);
    s(1'b0, OP_ACT, 1'b1, 2'h2, 13'h0011);
    s(1'b0, OP_ACT, 1'b1, 2'h0, 13'h0022);
    ddrcmd_ctrl_model_i.send(1'b0, OP_WR, 1'b1, 2'h2, 13'h0044, 16'h5AC3,
      2'h2);
    chk("wr_start", 16'h0001, 16'(n_wr - w0));
    chk("flag_low", 16'h0000, auto_close_flag);
    chk("col_bank", 16'h0002, 16'(col_bank));
    chk("core_word", 16'h00C3, last_word);
    chk("core_mask", 16'h0002, last_mask);
    chk("still_open", 16'h0005, bank_open);
    s(1'b0, OP_PRE, 1'b1, 2'h2, 13'h0000);
    chk("pre_one", 16'h0001, bank_open);
    s(1'b0, OP_PRE, 1'b1, 2'h3, ac);
    chk("pre_all", 16'h0000, bank_open);
  endtask
  task automatic sc_power();
    int r0;
    s(1'b0, OP_NOP, 1'b0, 2'h0, 13'h0000);
    chk("pd_pre", 16'h0001, power_down);
    s(1'b1, OP_NOP, 1'b1, 2'h0, 13'h0000);
    chk("pd_exit", 16'h0000, power_down);
    s(1'b0, OP_ACT, 1'b1, 2'h3, 13'h0100);
    s(1'b0, OP_NOP, 1'b0, 2'h0, 13'h0000);
    chk("pd_act", 16'h0001, active_power_down);
    s(1'b0, OP_NOP, 1'b1, 2'h0, 13'h0000);
    chk("pd_act_exit", 16'h0000, active_power_down);
    s(1'b0, OP_PRE, 1'b1, 2'h0, 13'h0400);
    s(1'b0, OP_REF, 1'b0, 2'h0, 13'h0000);
    chk("self_ref", 16'h0001, self_refresh);
    s(1'b0, OP_NOP, 1'b1, 2'h0, 13'h0000);
    chk("self_exit", 16'h0000, self_refresh);
    s(1'b0, OP_NOP, 1'b1, 2'h0, 13'h0000);
    r0 = n_ref;
    s(1'b0, OP_REF, 1'b1, 2'h0, 13'h0000);
    chk("refresh_after", 16'h0001, 16'(n_ref - r0));
    chk("no_reserved", 16'h0000, reserved_seen);
    s(1'b0, OP_RD, 1'b1, 2'h2, 13'h0000);
    chk("reserved", 16'h0001, reserved_seen);
  endtask
  initial begin
    rst_n = 1'b0;
    width_cfg = CFG_X16;
    do_reset(CFG_X16);
    sc_init();
    sc_access(AUTO_CLOSE_BIT_NARROW);
    sc_power();
    do_reset(CFG_X32);
    sc_init();
    sc_access(AUTO_CLOSE_BIT_X32);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("CHECK FAILED run_time expected done seen timeout");
    summarize();
  end
endmodule // tb_top
